// ---- alu_exec.v ----
// Purpose : executes add, add-with-carry and logical-and instructions
// Assumes : decoder offers opcode and following bytes with valid/ready;
//           data memory read is combinational on memRdAddr
// Notes   : memory writes are registered and land one cycle after
//           the execute cycle that produced them
`timescale 1ns/100ps
`default_nettype none
`include "alu_defines.vh"

module alu_exec (
  input  wire       clk,
  input  wire       reset,
  input  wire       instrValid,
  output wire       instrReady,
  input  wire [7:0] opcode,
  input  wire [7:0] operandByte1,
  input  wire [7:0] operandByte2,
  output reg  [7:0] memRdAddr,
  input  wire [7:0] memRdData,
  output wire       memWrEn,
  output wire [7:0] memWrAddr,
  output wire [7:0] memWrData,
  input  wire [7:0] portLatch0,
  input  wire [7:0] portLatch1,
  input  wire [7:0] portLatch2,
  input  wire [7:0] portLatch3,
  input  wire       accWrEn,
  input  wire [7:0] accWrData,
  input  wire       carryWrEn,
  input  wire       carryWrData,
  input  wire       regWrEn,
  input  wire [2:0] regWrIdx,
  input  wire [7:0] regWrData,
  output wire [7:0] acc,
  output wire       carryFlag,
  output wire       auxCarryFlag,
  output wire       overflowFlag,
  output wire       instrDone,
  output wire       illegalOp
);

  localparam ST_IDLE   = 1'b0;
  localparam ST_SECOND = 1'b1;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg        state_q;
  reg        state_d;
  reg  [7:0] acc_q;
  reg  [7:0] acc_d;
  reg        carry_q;
  reg        carry_d;
  reg        aux_q;
  reg        aux_d;
  reg        ovf_q;
  reg        ovf_d;
  reg  [7:0] opcode_q;
  reg  [7:0] addr_q;
  reg  [7:0] addr_d;
  reg  [7:0] imm_q;
  reg  [7:0] hold_q;
  reg  [7:0] hold_d;
  reg        wrEn_q;
  reg        wrEn_d;
  reg  [7:0] wrAddr_q;
  reg  [7:0] wrAddr_d;
  reg  [7:0] wrData_q;
  reg  [7:0] wrData_d;
  reg        done_q;
  reg        done_d;
  reg        illegal_q;
  reg        illegal_d;
  reg  [7:0] regFile [0:7];

  // ----------------------------------------------------------------
  // decode of the offered opcode
  // ----------------------------------------------------------------
  wire       take;
  wire       isAddImm;
  wire       isAddDir;
  wire       isAddInd;
  wire       isAddReg;
  wire       isAddcImm;
  wire       isAddcDir;
  wire       isAddcInd;
  wire       isAddcReg;
  wire       isAnlImm;
  wire       isAnlDir;
  wire       isAnlInd;
  wire       isAnlReg;
  wire       isAnlDirA;
  wire       isAnlDirImm;
  wire       isAnlBit;
  wire       isAnlNBit;
  wire       srcImm;
  wire       srcDir;
  wire       srcInd;
  wire       srcReg;
  wire       isAddAny;
  wire       isAddcAny;
  wire       isAnlAcc;
  wire       isBitOp;
  wire [7:0] pointer;
  wire [7:0] srcByte;
  wire [7:0] sum;
  wire       sumCarry;
  wire       sumAux;
  wire       sumOvf;
  wire       bitCarry;
  wire       heldBitInv;

  assign take = instrValid & (state_q == ST_IDLE);
  assign instrReady = (state_q == ST_IDLE);

  assign isAddImm  = (opcode == `OP_ADD_IMM);
  assign isAddDir  = (opcode == `OP_ADD_DIR);
  assign isAddInd  = (opcode[7:1] == `OP_ADD_IND);
  assign isAddReg  = (opcode[7:3] == `OP_ADD_REG);
  assign isAddcImm = (opcode == `OP_SUM_WITH_CARRY_OP_IMM);
  assign isAddcDir = (opcode == `OP_SUM_WITH_CARRY_OP_DIR);
  assign isAddcInd = (opcode[7:1] == `OP_SUM_WITH_CARRY_OP_IND);
  assign isAddcReg = (opcode[7:3] == `OP_SUM_WITH_CARRY_OP_REG);
  assign isAnlImm  = (opcode == `OP_ANL_IMM);
  assign isAnlDir  = (opcode == `OP_ANL_DIR);
  assign isAnlInd  = (opcode[7:1] == `OP_ANL_IND);
  assign isAnlReg  = (opcode[7:3] == `OP_ANL_REG);
  assign isAnlDirA = (opcode == `OP_ANL_DIR_A);
  assign isAnlDirImm = (opcode == `OP_ANL_DIR_IMM);
  // only a direct bit address follows these two opcodes
  assign isAnlBit  = (opcode == `OP_ANL_BIT);
  assign isAnlNBit = (opcode == `OP_ANL_NBIT);

  // four source modes shared by add, add-with-carry and and-to-acc
  assign srcImm = isAddImm | isAddcImm | isAnlImm;
  assign srcDir = isAddDir | isAddcDir | isAnlDir;
  assign srcInd = isAddInd | isAddcInd | isAnlInd;
  assign srcReg = isAddReg | isAddcReg | isAnlReg;
  assign isAddAny  = isAddImm | isAddDir | isAddInd | isAddReg;
  assign isAddcAny = isAddcImm | isAddcDir | isAddcInd | isAddcReg;
  assign isAnlAcc  = isAnlImm | isAnlDir | isAnlInd | isAnlReg;
  assign isBitOp   = isAnlBit | isAnlNBit;

  // pointer from R0 or R1, register from the low three bits
  assign pointer = regFile[{2'b00, opcode[0]}];

  assign srcByte = srcImm ? operandByte1 :
                   srcReg ? regFile[opcode[2:0]] :
                   memRdData;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function [7:0] bitToByte;
    input [7:0] bitAddr;
    begin
      if (bitAddr[`BIT_SFR_FLAG]) begin
        bitToByte = {bitAddr[7:3], 3'b000};
      end else begin
        bitToByte = `BIT_RAM_BASE + {4'b0000, bitAddr[6:3]};
      end
    end
  endfunction

  // read-modify-write on a port starts from what was last written
  function [7:0] rmwSource;
    input [7:0] addr;
    input [7:0] memVal;
    input [7:0] p0;
    input [7:0] p1;
    input [7:0] p2;
    input [7:0] p3;
    begin
      if (addr == `PORT0_ADDR) begin
        rmwSource = p0;
      end else if (addr == `PORT1_ADDR) begin
        rmwSource = p1;
      end else if (addr == `PORT2_ADDR) begin
        rmwSource = p2;
      end else if (addr == `PORT3_ADDR) begin
        rmwSource = p3;
      end else begin
        rmwSource = memVal;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // arithmetic and bit units
  // ----------------------------------------------------------------
  byte_adder u_adder (
    .addA        (acc_q),
    .addB        (srcByte),
    .carryIn     (isAddcAny & carry_q),
    .sum         (sum),
    .carryOut    (sumCarry),
    .auxCarryOut (sumAux),
    .overflowOut (sumOvf)
  );

  assign heldBitInv = (opcode_q == `OP_ANL_NBIT);

  bit_and_unit u_bit (
    .srcByte  (hold_q),
    .bitIdx   (addr_q[2:0]),
    .invert   (heldBitInv),
    .carryIn  (carry_q),
    .carryOut (bitCarry)
  );

  // ----------------------------------------------------------------
  // memory read address
  // ----------------------------------------------------------------
  always @* begin
    if (state_q == ST_SECOND) begin
      memRdAddr = addr_q;
    end else if (srcInd) begin
      memRdAddr = pointer;
    end else if (isBitOp) begin
      memRdAddr = bitToByte(operandByte1);
    end else begin
      memRdAddr = operandByte1;
    end
  end

  // ----------------------------------------------------------------
  // execute
  // ----------------------------------------------------------------
  always @* begin
    state_d   = state_q;
    acc_d     = accWrEn ? accWrData : acc_q;
    carry_d   = carryWrEn ? carryWrData : carry_q;
    aux_d     = aux_q;
    ovf_d     = ovf_q;
    addr_d    = addr_q;
    hold_d    = hold_q;
    wrEn_d    = 1'b0;
    wrAddr_d  = wrAddr_q;
    wrData_d  = wrData_q;
    done_d    = 1'b0;
    illegal_d = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (take) begin
          if (isAddAny | isAddcAny) begin
            acc_d   = sum;
            carry_d = sumCarry;
            aux_d   = sumAux;
            ovf_d   = sumOvf;
            done_d  = 1'b1;
          end else if (isAnlAcc) begin
            // flags are left as they were
            acc_d  = acc_q & srcByte;
            done_d = 1'b1;
          end else if (isAnlDirA) begin
            wrEn_d   = 1'b1;
            wrAddr_d = operandByte1;
            wrData_d = acc_q & rmwSource(operandByte1, memRdData,
                         portLatch0, portLatch1, portLatch2,
                         portLatch3);
            done_d   = 1'b1;
          end else if (isAnlDirImm) begin
            addr_d  = operandByte1;
            hold_d  = rmwSource(operandByte1, memRdData,
                        portLatch0, portLatch1, portLatch2,
                        portLatch3);
            state_d = ST_SECOND;
          end else if (isBitOp) begin
            addr_d  = operandByte1;
            hold_d  = memRdData;
            state_d = ST_SECOND;
          end else begin
            // unknown opcodes are consumed without side effects
            illegal_d = 1'b1;
            done_d    = 1'b1;
          end
        end
      end
      ST_SECOND: begin
        if (opcode_q == `OP_ANL_DIR_IMM) begin
          wrEn_d   = 1'b1;
          wrAddr_d = addr_q;
          wrData_d = hold_q & imm_q;
        end else begin
          carry_d = bitCarry;
        end
        done_d  = 1'b1;
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      state_q   <= ST_IDLE;
      acc_q     <= `ACC_RESET;
      carry_q   <= 1'b0;
      aux_q     <= 1'b0;
      ovf_q     <= 1'b0;
      opcode_q  <= `BYTE_ZERO;
      addr_q    <= `BYTE_ZERO;
      imm_q     <= `BYTE_ZERO;
      hold_q    <= `BYTE_ZERO;
      wrEn_q    <= 1'b0;
      wrAddr_q  <= `BYTE_ZERO;
      wrData_q  <= `BYTE_ZERO;
      done_q    <= 1'b0;
      illegal_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      acc_q     <= acc_d;
      carry_q   <= carry_d;
      aux_q     <= aux_d;
      ovf_q     <= ovf_d;
      addr_q    <= addr_d;
      hold_q    <= hold_d;
      wrEn_q    <= wrEn_d;
      wrAddr_q  <= wrAddr_d;
      wrData_q  <= wrData_d;
      done_q    <= done_d;
      illegal_q <= illegal_d;
      if (take) begin
        opcode_q <= opcode;
        imm_q    <= operandByte2;
      end
    end
  end

  // working registers are loaded by the core, not reset
  always @(posedge clk) begin
    if (regWrEn) begin
      regFile[regWrIdx] <= regWrData;
    end
  end

  assign memWrEn      = wrEn_q;
  assign memWrAddr    = wrAddr_q;
  assign memWrData    = wrData_q;
  assign acc          = acc_q;
  assign carryFlag    = carry_q;
  assign auxCarryFlag = aux_q;
  assign overflowFlag = ovf_q;
  assign instrDone    = done_q;
  assign illegalOp    = illegal_q;

endmodule // alu_exec

`default_nettype wire

// ---- alu_defines.vh ----
// Purpose : constants for the add / add-with-carry / logical-and unit
// Assumes : included by every design file of the unit
// Notes   : opcodes are full bytes unless a width says otherwise
//
// How it works
// - add sums source byte and accumulator, result back into accumulator.
// - add sets carry from bit 7 carry-out, aux carry from bit 3.
// - add sets overflow when carries out of bits 6 and 7 differ.
// - add forms take register, direct, indirect or immediate source.
// - add-with-carry sums source, carry flag and accumulator in one go.
// - add-with-carry flags follow the same bit 7, 3 and 6/7 rules.
// - and accumulator with direct byte is 0x55, two bytes, one cycle.
// - and accumulator with indirect register is 0x56/0x57, one byte.
// - and accumulator with immediate is 0x54, two bytes, one cycle.
// - and direct with accumulator is 0x52, result to direct, one cycle.
// - and direct with immediate is 0x53, three bytes, two cycles.
// - bit and clears carry on a zero source bit, no other flag moves.
// - complemented bit form uses inverted bit, stored bit untouched.
// - bit and accepts only direct bit addressing.
// - true bit and is 0x82 plus bit address, two bytes, two cycles.
// - complemented bit and is 0xb0 plus bit address, two cycles.
// - byte and stores bitwise and in destination, flags untouched.
// - and on an output port reads the output latch, not the pins.
`ifndef ALU_DEFINES_VH
`define ALU_DEFINES_VH

`define OP_ADD_IMM      8'h24
`define OP_ADD_DIR      8'h25
`define OP_ADD_IND      7'h13
`define OP_ADD_REG      5'h05
`define OP_SUM_WITH_CARRY_OP_IMM     8'h34
`define OP_SUM_WITH_CARRY_OP_DIR     8'h35
`define OP_SUM_WITH_CARRY_OP_IND     7'h1b
`define OP_SUM_WITH_CARRY_OP_REG     5'h07
`define OP_ANL_DIR_A    8'h52
`define OP_ANL_DIR_IMM  8'h53
`define OP_ANL_IMM      8'h54
`define OP_ANL_DIR      8'h55
`define OP_ANL_IND      7'h2b
`define OP_ANL_REG      5'h0b
`define OP_ANL_BIT      8'h82
`define OP_ANL_NBIT     8'hb0

`define BIT_SFR_FLAG    7
`define BIT_RAM_BASE    8'h20
`define PORT0_ADDR      8'h80
`define PORT1_ADDR      8'h90
`define PORT2_ADDR      8'ha0
`define PORT3_ADDR      8'hb0

`define AUX_CARRY_BIT   4
`define OVF_LOW_BIT     7
`define CARRY_BIT       8

`define ACC_RESET       8'h00
`define BYTE_ZERO       8'h00

`endif

// ---- byte_adder.v ----
// Purpose : ripple adder giving sum and carry, aux carry, overflow flags
// Assumes : purely combinational, used once per add instruction
// Notes   : carry chain is kept per bit so bits 3, 6 and 7 are visible
`timescale 1ns/100ps
`default_nettype none
`include "alu_defines.vh"

module byte_adder (
  input  wire [7:0] addA,
  input  wire [7:0] addB,
  input  wire       carryIn,
  output wire [7:0] sum,
  output wire       carryOut,
  output wire       auxCarryOut,
  output wire       overflowOut
);

  wire [8:0] chain;

  assign chain[0] = carryIn;

  // ----------------------------------------------------------------
  // per bit full adders
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_bit
      assign sum[i]     = addA[i] ^ addB[i] ^ chain[i];
      assign chain[i+1] = (addA[i] & addB[i]) |
                          (chain[i] & (addA[i] ^ addB[i]));
    end
  endgenerate

  assign carryOut    = chain[`CARRY_BIT];
  assign auxCarryOut = chain[`AUX_CARRY_BIT];
  // set only when the carries out of bit 6 and bit 7 disagree
  assign overflowOut = chain[`OVF_LOW_BIT] ^ chain[`CARRY_BIT];

endmodule // byte_adder

`default_nettype wire

// ---- bit_and_unit.v ----
// Purpose : and of the carry flag with one bit of a byte
// Assumes : byte already fetched, bit index from the bit address
// Notes   : never writes the source byte back
`timescale 1ns/100ps
`default_nettype none
`include "alu_defines.vh"

module bit_and_unit (
  input  wire [7:0] srcByte,
  input  wire [2:0] bitIdx,
  input  wire       invert,
  input  wire       carryIn,
  output wire       carryOut
);

  wire srcBit;

  // complement is applied to a copy only, the stored bit stays as it is
  assign srcBit   = srcByte[bitIdx] ^ invert;
  // a zero operand clears carry, a one leaves it alone
  assign carryOut = carryIn & srcBit;

endmodule // bit_and_unit

`default_nettype wire

// ---- alu_exec_props.sv ----
// Purpose : port-level checks of the add / and execution unit
// Assumes : one clock domain, reset synchronous and active high
// Notes   : add sums are modelled for the immediate forms only
`timescale 1ns/100ps
`default_nettype none
module alu_exec_props (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       instrValid,
  input wire logic       instrReady,
  input wire logic [7:0] opcode,
  input wire logic [7:0] operandByte1,
  input wire logic [7:0] memRdData,
  input wire logic       memWrEn,
  input wire logic [7:0] memWrAddr,
  input wire logic [7:0] memWrData,
  input wire logic [7:0] portLatch1,
  input wire logic [7:0] acc,
  input wire logic       carryFlag,
  input wire logic       auxCarryFlag,
  input wire logic       overflowFlag,
  input wire logic       instrDone
);
  logic       take;
  logic       immAdd;
  logic       cin;
  logic [8:0] sum9;
  logic       auxC;
  logic       ovfC;
  logic       srcBit;
  assign take   = instrValid && instrReady;
  // bit byte is on the read port in the take cycle
  assign srcBit = memRdData[operandByte1[2:0]];
  assign immAdd = take && (opcode == 8'h24 || opcode == 8'h34);
  // carry only feeds the add-with-carry opcode
  assign cin  = (opcode == 8'h34) ? carryFlag : 1'b0;
  assign sum9 = {1'b0, acc} + {1'b0, operandByte1} + {8'h00, cin};
  assign auxC = ({1'b0, acc[3:0]} + {1'b0, operandByte1[3:0]}
                + {4'h0, cin}) > 5'h0f;
  assign ovfC = sum9[8] ^ (({1'b0, acc[6:0]} + {1'b0, operandByte1[6:0]}
                + {7'h00, cin}) > 8'h7f);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_sum_carry: assert property (
    immAdd |=> instrDone && {carryFlag, acc} == $past(sum9))
    else $error("sum or carry wrong");
  a_aux_carry: assert property (
    immAdd |=> auxCarryFlag == $past(auxC))
    else $error("aux carry wrong");
  a_ovf_flag: assert property (
    immAdd |=> overflowFlag == $past(ovfC))
    else $error("overflow wrong");
  a_and_imm: assert property (
    take && opcode == 8'h54 |=> acc == ($past(acc) & $past(operandByte1))
      && $stable(carryFlag) && $stable(overflowFlag))
    else $error("and immediate wrong");
  a_and_direct: assert property (
    take && opcode == 8'h55 |=> instrDone
      && acc == ($past(acc) & $past(memRdData)))
    else $error("and direct wrong");
  a_dir_acc: assert property (
    take && opcode == 8'h52 && !operandByte1[7] |=> memWrEn && instrDone
      && memWrAddr == $past(operandByte1)
      && memWrData == ($past(acc) & $past(memRdData)))
    else $error("and to direct wrong");
  a_port_latch: assert property (
    take && opcode == 8'h52 && operandByte1 == 8'h90
      |=> memWrData == ($past(acc) & $past(portLatch1)))
    else $error("port latch not used");
  a_dir_imm_two: assert property (
    take && opcode == 8'h53 |=> !instrReady && !instrDone && !memWrEn
      ##1 instrDone && memWrEn && memWrAddr == $past(operandByte1, 2))
    else $error("three byte and timing wrong");
  a_bit_keeps: assert property (
    take && opcode == 8'h82 |=> !instrDone ##1 instrDone && !memWrEn
      && $stable(acc) && $stable(auxCarryFlag)
      && carryFlag == ($past(carryFlag, 2) & $past(srcBit, 2)))
    else $error("bit and flags wrong");
  a_nbit_write: assert property (
    take && opcode == 8'hb0 |=> !memWrEn && !instrReady
      ##1 !memWrEn && instrDone && $stable(acc)
      && carryFlag == ($past(carryFlag, 2) & !$past(srcBit, 2)))
    else $error("inverted bit and wrong");
endmodule // alu_exec_props

bind alu_exec alu_exec_props i_props (
  .clk(clk), .reset(reset), .instrValid(instrValid),
  .instrReady(instrReady), .opcode(opcode), .operandByte1(operandByte1),
  .memRdData(memRdData), .memWrEn(memWrEn), .memWrAddr(memWrAddr),
  .memWrData(memWrData), .portLatch1(portLatch1), .acc(acc),
  .carryFlag(carryFlag), .auxCarryFlag(auxCarryFlag),
  .overflowFlag(overflowFlag), .instrDone(instrDone));
`default_nettype wire

// ---- tb.sv ----
// Purpose : random self-checking bench for the execution unit
// Assumes : memory read is combinational, writes land next edge
// Notes   : core loads only while idle, so no same-cycle contest
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin nCompared++; if ((got) !== (exp)) begin \
  errorCnt++; $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end
module tb;
  logic        clk = 1'b0, reset = 1'b1, instrValid = 1'b0;
  logic [7:0]  opcode = 8'h00, operandByte1 = 8'h00, operandByte2 = 8'h00;
  logic        accWrEn = 1'b0, carryWrEn = 1'b0, carryWrData = 1'b0;
  logic        regWrEn = 1'b0;
  logic [2:0]  regWrIdx = 3'h0;
  logic [7:0]  accWrData = 8'h00, regWrData = 8'h00;
  logic [7:0]  pl [0:3];
  logic [7:0]  mem [0:255];
  logic [7:0]  regs [0:7];
  logic [7:0]  memRdAddr, memRdData, memWrAddr, memWrData, acc;
  logic        instrReady, memWrEn, carryFlag, auxCarryFlag, overflowFlag;
  logic        instrDone, illegalOp;
  logic [7:0]  eAcc = 8'h00;
  logic        eC = 1'b0, eAc = 1'b0, eOv = 1'b0;
  logic [28:0] expQ [$];
  logic [28:0] expV, gotV;
  int          errorCnt = 0, nCompared = 0, seed;
  logic [7:0]  opTab [0:16] = '{8'h24, 8'h25, 8'h26, 8'h28, 8'h34, 8'h35,
    8'h36, 8'h38, 8'h54, 8'h55, 8'h56, 8'h58, 8'h52, 8'h53, 8'h82, 8'hb0,
    8'ha5};

  always #50 clk = ~clk;
  assign memRdData = mem[memRdAddr];
  always @(posedge clk) if (memWrEn === 1'b1) mem[memWrAddr] <= memWrData;

  alu_exec i_dut (
    .clk(clk), .reset(reset), .instrValid(instrValid),
    .instrReady(instrReady), .opcode(opcode), .operandByte1(operandByte1),
    .operandByte2(operandByte2), .memRdAddr(memRdAddr),
    .memRdData(memRdData), .memWrEn(memWrEn), .memWrAddr(memWrAddr),
    .memWrData(memWrData), .portLatch0(pl[0]), .portLatch1(pl[1]),
    .portLatch2(pl[2]), .portLatch3(pl[3]), .accWrEn(accWrEn),
    .accWrData(accWrData), .carryWrEn(carryWrEn),
    .carryWrData(carryWrData), .regWrEn(regWrEn), .regWrIdx(regWrIdx),
    .regWrData(regWrData), .acc(acc), .carryFlag(carryFlag),
    .auxCarryFlag(auxCarryFlag), .overflowFlag(overflowFlag),
    .instrDone(instrDone), .illegalOp(illegalOp));

  // ---------------------------------------------------------------
  // result watcher
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (reset === 1'b0 && instrDone === 1'b1) begin
      expV = (expQ.size() > 0) ? expQ.pop_front() : 29'h1fffffff;
      gotV = {illegalOp, memWrEn, memWrEn ? {memWrAddr, memWrData} : 16'h0,
              acc, carryFlag, auxCarryFlag, overflowFlag};
      `CHK(gotV, expV)
    end
  end

  task automatic printVerdict;
    $display("compared %0d mismatches %0d", nCompared, errorCnt);
    if (errorCnt == 0 && nCompared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  function automatic logic [28:0] pack(input logic ill, wen,
                                       input logic [7:0] wa, wd);
    return {ill, wen, wen ? {wa, wd} : 16'h0, eAcc, eC, eAc, eOv};
  endfunction

  task automatic addModel(input logic [7:0] s, input logic ci);
    logic [8:0] t;
    t = {1'b0, eAcc} + {1'b0, s} + {8'h00, ci};
    eAc = ({1'b0, eAcc[3:0]} + {1'b0, s[3:0]} + {4'h0, ci}) > 5'h0f;
    eOv = t[8] ^ (({1'b0, eAcc[6:0]} + {1'b0, s[6:0]} + {7'h00, ci})
          > 8'h7f);
    {eC, eAcc} = t;
  endtask

  // hold the request until ready is seen; bounded so a hang ends the run
  task automatic issue(input logic [7:0] op, b1, b2);
    logic rdy;
    rdy = 1'b0;
    instrValid = 1'b1;
    opcode = op;
    operandByte1 = b1;
    operandByte2 = b2;
    for (int i = 0; i < 8 && !rdy; i++) begin
      @(negedge clk) rdy = (instrReady === 1'b1);
      @(posedge clk) #1;
    end
    if (!rdy) begin
      errorCnt++;
      printVerdict();
    end
  endtask

  // idle two cycles first so no two-cycle op still owns the carry
  task automatic coreLoad;
    instrValid = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    accWrEn = 1'b1;
    carryWrEn = 1'b1;
    accWrData = 8'($random(seed));
    carryWrData = accWrData[3];
    eAcc = accWrData;
    eC = carryWrData;
    @(posedge clk) #1;
    accWrEn = 1'b0;
    carryWrEn = 1'b0;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] r;
    logic [7:0]  op, b1, b2, s, d, wd, ba;
    logic        ill, wen;
    seed = 44360;
    for (int i = 0; i < 4; i++) pl[i] = 8'($random(seed));
    for (int i = 0; i < 256; i++) mem[i] = 8'($random(seed));
    repeat (12) @(posedge clk);
    #1;
    reset = 1'b0;
    `CHK({instrReady, acc, carryFlag, auxCarryFlag, overflowFlag, instrDone,
          memWrEn}, 14'h2000)
    for (int k = 0; k < 8; k++) begin
      r = $random(seed);
      // pointers stay in the data area above the bit bytes
      regs[k] = (k < 2) ? 8'h30 + {1'b0, r[6:0]} % 8'h50 : r[15:8];
      regWrEn = 1'b1;
      regWrIdx = k[2:0];
      regWrData = regs[k];
      @(posedge clk) #1;
    end
    regWrEn = 1'b0;
    for (int k = 0; k < 400; k++) begin
      if (k % 16 == 15) coreLoad();
      r = $random(seed);
      op = opTab[r[15:8] % 17];
      if (op[3]) op = op | {5'h00, r[2:0]};
      else if (op[3:1] == 3'b011) op = op | {7'h00, r[0]};
      b1 = r[23:16];
      b2 = r[31:24];
      pl[r[5:4]] = b2 ^ r[7:0];
      if (op[3:0] == 4'h5 || op[7:1] == 7'h29)
        b1 = 8'h30 + {1'b0, b1[6:0]} % 8'h50;
      if (op[7:1] == 7'h29 && r[3]) b1 = {2'b10, r[5:4], 4'h0};
      case (op[3:0])
        4'h4: s = b1;
        4'h5: s = mem[b1];
        4'h6, 4'h7: s = mem[regs[op[0]]];
        default: s = regs[op[2:0]];
      endcase
      d = (b1[7] && b1[3:0] == 4'h0) ? pl[b1[5:4]] : mem[b1];
      ill = 1'b0;
      wen = 1'b0;
      wd = 8'h00;
      if (op[7:5] == 3'b001) addModel(s, op[4] & eC);
      else if (op[7:4] == 4'h5 && op[3:2] != 2'b00) eAcc = eAcc & s;
      else if (op == 8'h52) begin
        wen = 1'b1;
        wd = d & eAcc;
      end else if (op == 8'h53) begin
        wen = 1'b1;
        wd = d & b2;
      end else if (op == 8'h82 || op == 8'hb0) begin
        ba = b1[7] ? (b1 & 8'hf8) : 8'h20 + {4'h0, b1[6:3]};
        eC = eC & (mem[ba][b1[2:0]] ^ op[5]);
      end else ill = 1'b1;
      expQ.push_back(pack(ill, wen, b1, wd));
      issue(op, b1, b2);
    end
    instrValid = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    `CHK(32'(expQ.size()), 32'h0)
    printVerdict();
  end
endmodule // tb
`default_nettype wire
